// >>> rtl/iap_ctrl.sv
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/1ns
`include "iap_defs.svh"
// Contract
// R1: Mode 110 makes the protect-enable bit arm unlock mode.
// R2: Raising protect-enable in unlock mode starts the unlock window timer.
// R3: Key 00,0D,C3 in low and 04,09,40 in high data registers one to three.
// R4: Timer expiry clears protect-enable regardless of the key.
// R5: Correct key sets the erase/write enabled flag; wrong key leaves it low.
// R6: Software clearing the enabled flag locks erase/write at once.
// R7: Write buffer is 32 words of 16 bits; page chosen by address bits 13..5.
// R8: Writing first data high loads the word and increments the address.
// R9: Address increments stop at the last word of the page.
// R10: Mode 001 with write trigger erases the page; trigger clears when done.
// R11: Mode 000 with write trigger programs the buffer; trigger clears when done.
// R12: Erase always acts on a whole page.
// R13: CPU is halted while erase or write runs.
// R14: Time select bit chooses how long the write trigger stays high.
// R15: After clear and reload, the same page may be written again without erase.
// R16: Mode 011 with read enable and read trigger fetches a word into data zero.
// R17: Reading needs no unlock.
// R18: Software writes the key promptly before the unlock timer expires.
// R19: Software verifies after writing and retries with clear and reload.
// R20: Software runs the system clock at its fastest while programming.
// R21: Erase and write are refused unless the enabled flag is set.
// R22: Times: select 0 gives 3.2ms/2.2ms, select 1 gives 3.7ms/3.0ms.
// R23: Buffer clear bit starts a clear; hardware drops it when finished.
// R24: Writing first data low only updates that register.
// R25: Dummy writes to first data high tag addresses, stopping at offset 11111b.
// R26: Read trigger without read enable or read mode starts nothing.
module iap_ctrl #(
    parameter int unsigned ERASE0_CYC =
        (`IAP_T_ERASE0_NS + `IAP_CLK_PERIOD_NS - 1) / `IAP_CLK_PERIOD_NS,
    parameter int unsigned WRITE0_CYC =
        (`IAP_T_WRITE0_NS + `IAP_CLK_PERIOD_NS - 1) / `IAP_CLK_PERIOD_NS,
    parameter int unsigned ERASE1_CYC =
        (`IAP_T_ERASE1_NS + `IAP_CLK_PERIOD_NS - 1) / `IAP_CLK_PERIOD_NS,
    parameter int unsigned WRITE1_CYC =
        (`IAP_T_WRITE1_NS + `IAP_CLK_PERIOD_NS - 1) / `IAP_CLK_PERIOD_NS,
    parameter int unsigned PAGE_WORDS = 32
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output iap_pkg::iap_flash_s flash_req,
    input wire logic [15:0] flash_rdata,
    output logic cpu_halt
);
    localparam int unsigned UNLOCK_CYC =
        (`IAP_T_UNLOCK_NS + `IAP_CLK_PERIOD_NS - 1) / `IAP_CLK_PERIOD_NS;
    localparam int CW = 20;

    // ==========================================================
    // Elaboration checks
    if (PAGE_WORDS != 32)
        $error("iap_ctrl: page must be 32 words");
    if (ERASE1_CYC >= (1 << CW) || ERASE0_CYC >= (1 << CW) || WRITE0_CYC >= (1 << CW)
        || WRITE1_CYC >= (1 << CW) || ERASE0_CYC == 0 || WRITE0_CYC == 0
        || ERASE1_CYC == 0 || WRITE1_CYC == 0)
        $error("iap_ctrl: operation count out of range");

    // ==========================================================
    // Reset release
    logic rst_q1;
    logic rst_q2;
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_q1 <= 1'b0;
            rst_q2 <= 1'b0;
        end
        else
        begin
            rst_q1 <= 1'b1;
            rst_q2 <= rst_q1;
        end
    end
    logic rst_sync_b;
    assign rst_sync_b = rst_q2;

    // ==========================================================
    // Registers and state
    logic [2:0] op_mode_field_q;
    logic protect_enable_bit_q;
    logic write_trigger_bit_q;
    logic read_trigger_bit_q;
    logic erase_write_enabled_flag_q;
    logic read_enable_bit_q;
    logic erase_write_time_select_q;
    logic buffer_clear_bit_q;
    logic [13:0] flash_addr_q;
    logic [7:0] data_q [0:7];
    logic [15:0] wbuf_q [0:PAGE_WORDS-1];
    logic [PAGE_WORDS-1:0] wvalid_q;
    iap_pkg::iap_state_e state_q;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] unlock_cnt_q;
    logic [4:0] idx_q;

    logic wr_ctrl0;
    logic wr_ctrl1;
    logic wr_ctrl2;
    logic wr_addrl;
    logic wr_addrh;
    logic wr_data0h;
    logic unlock_expire;
    logic key_good;
    logic start_erase;
    logic start_prog;
    logic start_read;
    logic start_clear;
    logic [CW-1:0] op_cycles;

    assign wr_ctrl0 = reg_wr && reg_addr == `IAP_OFS_CTRL0;
    assign wr_ctrl1 = reg_wr && reg_addr == `IAP_OFS_CTRL1;
    assign wr_ctrl2 = reg_wr && reg_addr == `IAP_OFS_CTRL2;
    assign wr_addrl = reg_wr && reg_addr == `IAP_OFS_ADDRL;
    assign wr_addrh = reg_wr && reg_addr == `IAP_OFS_ADDRH;
    assign wr_data0h = reg_wr && reg_addr == (`IAP_OFS_DATA0L + 8'h01);

    assign unlock_expire = protect_enable_bit_q && unlock_cnt_q == CW'(1);
    assign key_good = {data_q[6], data_q[4], data_q[2]} == `IAP_KEY_LOW  // see R3
        && {data_q[7], data_q[5], data_q[3]} == `IAP_KEY_HIGH;

    // Triggers only start from idle; the CPU is halted otherwise
    assign start_erase = state_q == iap_pkg::st_idle && wr_ctrl0
        && reg_wdata[`IAP_BIT_WT] && erase_write_enabled_flag_q  // see R21
        && reg_wdata[`IAP_MODE_HI:`IAP_MODE_LO] == `IAP_MODE_ERASE;  // see R10
    assign start_prog = state_q == iap_pkg::st_idle && wr_ctrl0
        && reg_wdata[`IAP_BIT_WT] && erase_write_enabled_flag_q  // see R21
        && reg_wdata[`IAP_MODE_HI:`IAP_MODE_LO] == `IAP_MODE_WRITE;  // see R11
    assign start_read = state_q == iap_pkg::st_idle && wr_ctrl0
        && reg_wdata[`IAP_BIT_RD] && read_enable_bit_q  // see R26
        && reg_wdata[`IAP_MODE_HI:`IAP_MODE_LO] == `IAP_MODE_READ;  // see R16 R17
    assign start_clear = state_q == iap_pkg::st_idle && wr_ctrl2
        && reg_wdata[`IAP_BIT_CLR];  // see R23

    always_comb
    begin
        if (state_q == iap_pkg::st_erase || op_mode_field_q == `IAP_MODE_ERASE)
            op_cycles = erase_write_time_select_q ? CW'(ERASE1_CYC) : CW'(ERASE0_CYC);
        else
            op_cycles = erase_write_time_select_q ? CW'(WRITE1_CYC) : CW'(WRITE0_CYC);
    end  // see R14 R22

    // ==========================================================
    // Control registers zero to two
    always_ff @(posedge clock or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
            op_mode_field_q <= 3'h0;
        else if (wr_ctrl0 && state_q == iap_pkg::st_idle)
            op_mode_field_q <= reg_wdata[`IAP_MODE_HI:`IAP_MODE_LO];
    end

    always_ff @(posedge clock or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            protect_enable_bit_q <= 1'b0;
            unlock_cnt_q <= '0;
        end
        else if (unlock_expire)
        begin
            protect_enable_bit_q <= 1'b0;  // see R4
            unlock_cnt_q <= '0;
        end
        else if (wr_ctrl0 && !protect_enable_bit_q && reg_wdata[`IAP_BIT_PEN]
                 && reg_wdata[`IAP_MODE_HI:`IAP_MODE_LO] == `IAP_MODE_UNLOCK)  // see R1
        begin
            protect_enable_bit_q <= 1'b1;
            unlock_cnt_q <= CW'(UNLOCK_CYC);  // see R2
        end
        else if (protect_enable_bit_q)
            unlock_cnt_q <= unlock_cnt_q - CW'(1);
    end

    // Set at expiry wins over a software clear in the same cycle
    always_ff @(posedge clock or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
            erase_write_enabled_flag_q <= 1'b0;
        else if (unlock_expire && key_good)
            erase_write_enabled_flag_q <= 1'b1;  // see R5
        else if (wr_ctrl0 && !reg_wdata[`IAP_BIT_EWEN])
            erase_write_enabled_flag_q <= 1'b0;  // see R6
    end

    always_ff @(posedge clock or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            read_enable_bit_q <= 1'b0;
            erase_write_time_select_q <= 1'b0;
        end
        else
        begin
            if (wr_ctrl1)
                read_enable_bit_q <= reg_wdata[`IAP_BIT_RDEN];
            if (wr_ctrl2 && state_q == iap_pkg::st_idle)
                erase_write_time_select_q <= reg_wdata[`IAP_BIT_TSEL];
        end
    end

    // ==========================================================
    // Sequencer
    always_ff @(posedge clock or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            state_q <= iap_pkg::st_idle;
            cnt_q <= '0;
            idx_q <= 5'h0;
            write_trigger_bit_q <= 1'b0;
            read_trigger_bit_q <= 1'b0;
            buffer_clear_bit_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                iap_pkg::st_idle:
                begin
                    idx_q <= 5'h0;
                    if (start_erase)
                    begin
                        state_q <= iap_pkg::st_erase;
                        write_trigger_bit_q <= 1'b1;
                    end
                    else if (start_prog)
                    begin
                        state_q <= iap_pkg::st_prog;
                        write_trigger_bit_q <= 1'b1;
                    end
                    else if (start_read)
                    begin
                        state_q <= iap_pkg::st_read;
                        read_trigger_bit_q <= 1'b1;
                        cnt_q <= CW'(`IAP_READ_CYC);
                    end
                    else if (start_clear)
                    begin
                        state_q <= iap_pkg::st_clear;
                        buffer_clear_bit_q <= 1'b1;
                    end
                end
                iap_pkg::st_erase:
                begin
                    state_q <= iap_pkg::st_wait;  // see R12
                    cnt_q <= op_cycles;
                end
                iap_pkg::st_prog:
                begin
                    idx_q <= idx_q + 5'h1;
                    if (idx_q == `IAP_PAGE_LAST)
                    begin
                        state_q <= iap_pkg::st_wait;
                        cnt_q <= op_cycles;
                    end
                end
                iap_pkg::st_wait:
                begin
                    cnt_q <= cnt_q - CW'(1);
                    if (cnt_q == CW'(1))
                    begin
                        state_q <= iap_pkg::st_idle;
                        write_trigger_bit_q <= 1'b0;  // see R10 R11
                    end
                end
                iap_pkg::st_read:
                begin
                    cnt_q <= cnt_q - CW'(1);
                    if (cnt_q == CW'(1))
                    begin
                        state_q <= iap_pkg::st_idle;
                        read_trigger_bit_q <= 1'b0;  // see R16
                    end
                end
                iap_pkg::st_clear:
                begin
                    idx_q <= idx_q + 5'h1;
                    if (idx_q == `IAP_PAGE_LAST)
                    begin
                        state_q <= iap_pkg::st_idle;
                        buffer_clear_bit_q <= 1'b0;  // see R23
                    end
                end
                default:
                    state_q <= iap_pkg::st_idle;
            endcase
        end
    end

    assign cpu_halt = state_q != iap_pkg::st_idle;  // see R13

    // ==========================================================
    // Address pair and data registers
    always_ff @(posedge clock or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
            flash_addr_q <= 14'h0;
        else if (wr_addrl)
            flash_addr_q[7:0] <= reg_wdata;
        else if (wr_addrh)
            flash_addr_q[13:8] <= reg_wdata[5:0];
        else if (wr_data0h && flash_addr_q[4:0] != `IAP_PAGE_LAST)  // see R9 R25
            flash_addr_q <= flash_addr_q + 14'h1;  // see R8
    end

    for (genvar g = 0; g < 8; g++)
    begin : g_data
        always_ff @(posedge clock or negedge rst_sync_b)
        begin
            if (!rst_sync_b)
                data_q[g] <= 8'h0;
            else if (state_q == iap_pkg::st_read && cnt_q == CW'(1) && g < 2)
                data_q[g] <= g == 0 ? flash_rdata[7:0] : flash_rdata[15:8];
            else if (reg_wr && reg_addr == `IAP_OFS_DATA0L + 8'(g))
                data_q[g] <= reg_wdata;  // see R24
        end
    end

    // ==========================================================
    // Write buffer: one word per clear step keeps it a plain RAM
    always_ff @(posedge clock)
    begin
        if (state_q == iap_pkg::st_clear)
            wbuf_q[idx_q] <= 16'h0;
        else if (wr_data0h && state_q == iap_pkg::st_idle)
            wbuf_q[flash_addr_q[4:0]] <= {reg_wdata, data_q[0]};  // see R7 R8
    end

    always_ff @(posedge clock or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
            wvalid_q <= '0;
        else if (state_q == iap_pkg::st_clear)
            wvalid_q[idx_q] <= 1'b0;  // see R15
        else if (wr_data0h && state_q == iap_pkg::st_idle)
            wvalid_q[flash_addr_q[4:0]] <= 1'b1;
    end

    // ==========================================================
    // Flash array requests
    always_ff @(posedge clock or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
            flash_req <= '0;
        else
        begin
            flash_req.erase_stb <= state_q == iap_pkg::st_erase;  // see R12
            flash_req.prog_stb <= state_q == iap_pkg::st_prog && wvalid_q[idx_q];
            flash_req.rd_stb <= start_read;
            if (state_q == iap_pkg::st_prog)
                flash_req.addr <= {flash_addr_q[13:5], idx_q};  // see R7
            else if (state_q == iap_pkg::st_erase)
                flash_req.addr <= {flash_addr_q[13:5], 5'h0};
            else
                flash_req.addr <= flash_addr_q;
            flash_req.wdata <= state_q == iap_pkg::st_prog ? wbuf_q[idx_q] : 16'h0;
        end
    end

    // ==========================================================
    // Register read port
    always_ff @(posedge clock or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
            reg_rdata <= 8'h0;
        else if (!reg_rd)
            reg_rdata <= 8'h0;
        else if (reg_addr == `IAP_OFS_CTRL0)
            reg_rdata <= {1'b0, op_mode_field_q, protect_enable_bit_q, write_trigger_bit_q,
                          read_trigger_bit_q, erase_write_enabled_flag_q};
        else if (reg_addr == `IAP_OFS_CTRL1)
            reg_rdata <= {7'h0, read_enable_bit_q};
        else if (reg_addr == `IAP_OFS_CTRL2)
            reg_rdata <= {6'h0, erase_write_time_select_q, buffer_clear_bit_q};
        else if (reg_addr == `IAP_OFS_ADDRL)
            reg_rdata <= flash_addr_q[7:0];
        else if (reg_addr == `IAP_OFS_ADDRH)
            reg_rdata <= {2'h0, flash_addr_q[13:8]};
        else if (reg_addr >= `IAP_OFS_DATA0L && reg_addr <= `IAP_OFS_DATA3H)
            reg_rdata <= data_q[3'(reg_addr - `IAP_OFS_DATA0L)];
        else
            reg_rdata <= 8'h0;
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_sync_b);

    sequence seq_read_start;
        state_q == iap_pkg::st_idle && start_read;
    endsequence
    sequence seq_read_done;
        read_trigger_bit_q ##1 !read_trigger_bit_q && state_q == iap_pkg::st_idle;
    endsequence

    unlock_expire_a: assert property (unlock_expire |=> !protect_enable_bit_q) // see R4
        else $error("protect enable not cleared at expiry");
    key_good_a: assert property (unlock_expire && key_good |=> erase_write_enabled_flag_q) // see R5
        else $error("good key did not enable");
    key_bad_a: assert property (!erase_write_enabled_flag_q && !(unlock_expire && key_good)
        |=> !erase_write_enabled_flag_q) // see R5
        else $error("enabled flag rose without good key");
    lock_clear_a: assert property (wr_ctrl0 && !reg_wdata[`IAP_BIT_EWEN] && !unlock_expire
        |=> !erase_write_enabled_flag_q) // see R6
        else $error("software clear did not lock");
    refuse_locked_a: assert property (state_q == iap_pkg::st_idle && !erase_write_enabled_flag_q
        |=> state_q != iap_pkg::st_erase && state_q != iap_pkg::st_prog) // see R21
        else $error("erase or write started while locked");
    halt_busy_a: assert property (write_trigger_bit_q |-> cpu_halt) // see R13
        else $error("cpu not halted during operation");
    addr_step_a: assert property (wr_data0h && flash_addr_q[4:0] != `IAP_PAGE_LAST
        |=> flash_addr_q == $past(flash_addr_q) + 14'h1) // see R8
        else $error("address did not step");
    addr_hold_a: assert property (wr_data0h && flash_addr_q[4:0] == `IAP_PAGE_LAST
        |=> $stable(flash_addr_q)) // see R9
        else $error("address passed page end");
    read_fetch_a: assert property (seq_read_start |=> ##[2:4] seq_read_done) // see R16
        else $error("read did not complete in time");
    read_refuse_a: assert property (wr_ctrl0 && reg_wdata[`IAP_BIT_RD] && !read_enable_bit_q
        |=> !read_trigger_bit_q) // see R26
        else $error("read started without enable");
    clear_done_a: assert property (start_clear |=> buffer_clear_bit_q [*8] ##[24:25]
        !buffer_clear_bit_q) // see R23
        else $error("buffer clear length wrong");
endmodule

// >>> rtl/iap_defs.svh
`ifndef IAP_DEFS_SVH
`define IAP_DEFS_SVH
// ==========================================================
// Register offsets
`define IAP_OFS_CTRL0 8'h00
`define IAP_OFS_CTRL1 8'h01
`define IAP_OFS_CTRL2 8'h02
`define IAP_OFS_ADDRL 8'h03
`define IAP_OFS_ADDRH 8'h04
`define IAP_OFS_DATA0L 8'h05
`define IAP_OFS_DATA3H 8'h0c
// ==========================================================
// Field positions
`define IAP_MODE_HI 6
`define IAP_MODE_LO 4
`define IAP_BIT_PEN 3
`define IAP_BIT_WT 2
`define IAP_BIT_RD 1
`define IAP_BIT_EWEN 0
`define IAP_BIT_RDEN 0
`define IAP_BIT_TSEL 1
`define IAP_BIT_CLR 0
// ==========================================================
// Mode codes and unlock key
`define IAP_MODE_WRITE 3'h0
`define IAP_MODE_ERASE 3'h1
`define IAP_MODE_READ 3'h3
`define IAP_MODE_UNLOCK 3'h6
`define IAP_KEY_LOW 24'hc30d00
`define IAP_KEY_HIGH 24'h400904
// ==========================================================
// Timing and last word of a page
`define IAP_CLK_PERIOD_NS 40
`define IAP_T_ERASE0_NS 3200000
`define IAP_T_WRITE0_NS 2200000
`define IAP_T_ERASE1_NS 3700000
`define IAP_T_WRITE1_NS 3000000
`define IAP_T_UNLOCK_NS 100000
`define IAP_READ_CYC 3
`define IAP_PAGE_LAST 5'h1f
`endif

// >>> rtl/iap_pkg.sv
package iap_pkg;
    typedef enum logic [2:0] {st_idle, st_erase, st_prog, st_wait, st_read, st_clear} iap_state_e;
    typedef struct packed {
        logic erase_stb;
        logic prog_stb;
        logic rd_stb;
        logic [13:0] addr;
        logic [15:0] wdata;
    } iap_flash_s;
endpackage

// >>> testbench/iap_flash_model.sv
`timescale 1ns/1ns
// ==========================================================
// Flash array: read data stands three cycles, then shows the inverse
module iap_flash_model (
    input wire logic clock,
    input wire iap_pkg::iap_flash_s flash_req,
    output logic [15:0] flash_rdata
);
    logic [15:0] mem [int];
    logic [15:0] val_q = 16'h0000;
    logic [1:0] hold_q = 2'h0;
    int prog_cnt = 0;
    logic [13:0] erase_addr = 14'h0000;
    always @(posedge clock)
    begin
        if (flash_req.erase_stb)
        begin
            erase_addr = flash_req.addr;
            for (int i = 0; i < 32; i++)
                mem.delete({flash_req.addr[13:5], i[4:0]});
        end
        if (flash_req.prog_stb)
        begin
            prog_cnt++;
            mem[flash_req.addr] = flash_req.wdata;
        end
        if (flash_req.rd_stb)
        begin
            val_q <= mem.exists(flash_req.addr) ? mem[flash_req.addr] : 16'h0000;
            hold_q <= 2'h3;
        end
        else if (hold_q != 2'h0)
            hold_q <= hold_q - 2'h1;
    end
    // A stale value would let a late sample pass unnoticed
    assign flash_rdata = (hold_q != 2'h0) ? val_q : ~val_q;
endmodule

// >>> testbench/iap_flash_program_controller_tb.sv
`timescale 1ns/1ns
`include "iap_defs.svh"
module iap_flash_program_controller_tb;
    localparam int E0 = 20;
    localparam int W0 = 10;
    localparam int E1 = 30;
    localparam int W1 = 15;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    iap_pkg::iap_flash_s flash_req;
    logic [15:0] flash_rdata;
    logic cpu_halt;
    int err_count = 0;
    int samples_checked = 0;
    logic [7:0] v;
    logic [15:0] w;
    int n;
    int pc;
    always #20 clock = ~clock;
    iap_ctrl #(.ERASE0_CYC(E0), .WRITE0_CYC(W0), .ERASE1_CYC(E1), .WRITE1_CYC(W1)) u_iap_ctrl (
        .clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_req(flash_req),
        .flash_rdata(flash_rdata), .cpu_halt(cpu_halt));
    iap_flash_model u_iap_flash_model (
        .clock(clock), .flash_req(flash_req), .flash_rdata(flash_rdata));
    // ==========================================================
    // Bus and check helpers
    task automatic wrap_up;
        $display("checked %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    // Counts halted cycles; a hang ends the run
    task automatic wait_idle;
        n = 0;
        #1;
        while (cpu_halt !== 1'b0)
        begin
            @(posedge clock);
            #1 n++;
            if (n > 200)
            begin
                chk("halt_timeout", 16'h0001, 16'h0000);
                wrap_up();
            end
        end
    endtask
    task automatic span(input string nm, input int e);
        chk(nm, 16'(n >= e && n <= e + 2), 16'h0001);
    endtask
    task automatic rdw(input logic [13:0] a);
        wr(8'h01, 8'h01);
        wr(8'h03, a[7:0]);
        wr(8'h04, {2'b00, a[13:8]});
        wr(8'h00, 8'h33);
        wait_idle();
        span("read_time", 3);
        rd(8'h05);
        w[7:0] = v;
        rd(8'h06);
        w[15:8] = v;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_locked;
        rd(8'h00);
        chk("ctrl0_reset", v, 8'h00);
        rd(8'h20);
        chk("unmapped", v, 8'h00);
        wr(8'h00, 8'h04);
        #1 chk("halt_locked", cpu_halt, 1'b0);
        rd(8'h00);
        chk("trig_locked", v[2], 1'b0);
        wr(8'h00, 8'h32);
        #1 chk("read_no_en", cpu_halt, 1'b0);
        wr(8'h01, 8'h01);
        wr(8'h00, 8'h02);
        #1 chk("read_bad_mode", cpu_halt, 1'b0);
        $display("locked test done");
    endtask
    task automatic t_unlock(input logic good);
        logic [23:0] lo;
        logic [23:0] hi;
        lo = good ? `IAP_KEY_LOW : 24'hc30d01;
        hi = `IAP_KEY_HIGH;
        wr(8'h00, 8'h68);
        rd(8'h00);
        chk("armed", v[3], 1'b1);
        for (int i = 0; i < 3; i++)
        begin
            wr(8'h07 + 8'(2 * i), lo[8 * i +: 8]);
            wr(8'h08 + 8'(2 * i), hi[8 * i +: 8]);
        end
        repeat (2600) @(posedge clock);
        rd(8'h00);
        chk("pen_expired", v[3], 1'b0);
        chk("enabled", v[0], good);
        $display("unlock test done");
    endtask
    task automatic t_erase(input logic ts, input int e);
        wr(8'h02, {6'h00, ts, 1'b0});
        wr(8'h03, 8'h40);
        wr(8'h04, 8'h00);
        wr(8'h00, 8'h11);
        for (int i = 0; i < 32; i++)
            wr(8'h06, 8'hff);
        wr(8'h00, 8'h15);
        wait_idle();
        span("erase_time", e);
        rd(8'h00);
        chk("erase_trig", v[2], 1'b0);
        chk("erase_page", {2'b00, u_iap_flash_model.erase_addr}, 16'h0040);
        $display("erase test done");
    endtask
    task automatic t_write;
        wr(8'h02, 8'h01);
        wait_idle();
        span("clear_time", 32);
        rd(8'h02);
        chk("clear_bit", v[0], 1'b0);
        wr(8'h03, 8'h40);
        wr(8'h00, 8'h01);
        pc = u_iap_flash_model.prog_cnt;
        for (int i = 0; i <= 32; i++)
        begin
            wr(8'h05, 8'(i));
            wr(8'h06, 8'ha0);
        end
        wr(8'h00, 8'h05);
        wait_idle();
        // All 32 word slots are stepped through before the timed wait starts
        span("write_time", W0 + 32);
        chk("prog_words", 16'(u_iap_flash_model.prog_cnt - pc), 16'h0020);
        rdw(14'h0040);
        chk("word_first", w, 16'ha000);
        rdw(14'h005f);
        chk("word_last", w, 16'ha020);
        $display("write test done");
    endtask
    task automatic t_rewrite;
        wr(8'h02, 8'h03);
        wait_idle();
        wr(8'h03, 8'h43);
        wr(8'h00, 8'h01);
        pc = u_iap_flash_model.prog_cnt;
        wr(8'h05, 8'h3c);
        wr(8'h06, 8'h5a);
        wr(8'h05, 8'h99);
        wr(8'h00, 8'h05);
        wait_idle();
        span("write1_time", W1 + 32);
        chk("prog_one", 16'(u_iap_flash_model.prog_cnt - pc), 16'h0001);
        rdw(14'h0043);
        chk("rewritten", w, 16'h5a3c);
        wr(8'h00, 8'h00);
        rd(8'h00);
        chk("relocked", v[0], 1'b0);
        wr(8'h00, 8'h15);
        #1 chk("erase_relocked", cpu_halt, 1'b0);
        rdw(14'h0043);
        chk("read_locked", w, 16'h5a3c);
        $display("rewrite test done");
    endtask
    // ==========================================================
    // Clock stays at the full rate throughout programming
    initial
    begin
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        repeat (4) @(posedge clock);
        t_locked();
        t_unlock(1'b0);
        t_unlock(1'b1);
        t_erase(1'b0, E0);
        t_erase(1'b1, E1);
        t_write();
        t_rewrite();
        wrap_up();
    end
endmodule
